// ### rtl/dpc_defs.vh
// Constants for the dual-port RAM port controller
`ifndef DPC_DEFS_VH
`define DPC_DEFS_VH

// Timing figures in ns and the 125 MHz clock period
`define DPC_CLK_PERIOD_NS 8
`define DPC_T_ADDR_SETUP_NS 0
`define DPC_T_WRITE_PULSE_NS 12
`define DPC_T_DATA_SETUP_NS 10
`define DPC_T_ADDR_HOLD_NS 2
`define DPC_T_READ_ACCESS_NS 15
`define DPC_T_OUT_OFF_NS 10
`define DPC_T_SEM_GAP_NS 10
`define DPC_T_BUSY_VALID_NS 15

// Least times round up, never below one cycle
`define DPC_CYC_UP(ns) (((ns) + `DPC_CLK_PERIOD_NS - 1) / `DPC_CLK_PERIOD_NS < 1 ? 1 : \
    ((ns) + `DPC_CLK_PERIOD_NS - 1) / `DPC_CLK_PERIOD_NS)

// Controller states
`define DPC_ST_IDLE 3'h0
`define DPC_ST_SETUP 3'h1
`define DPC_ST_STROBE 3'h2
`define DPC_ST_HOLD 3'h3
`define DPC_ST_GAP 3'h4
`define DPC_ST_WAIT 3'h5

// Command codes
`define DPC_CMD_RAM_READ 2'h0
`define DPC_CMD_RAM_WRITE 2'h1
`define DPC_CMD_SEM_READ 2'h2
`define DPC_CMD_SEM_WRITE 2'h3

// Semaphore data bit and counter width
`define DPC_SEM_BIT 0
`define DPC_CNT_W 4

`endif

// ### rtl/dpc_port_ctrl.v
// Port-side controller that drives one port of an asynchronous dual-port RAM
`timescale 1ns/100ps
`default_nettype none
`include "dpc_defs.vh"

module dpc_port_ctrl #(
    parameter ADDR_W = 13,
    parameter DATA_W = 9
) (
    input  wire              clk_sys_in,
    input  wire              nrst_in,
    input  wire              req_valid_in,
    input  wire [1:0]        req_cmd_in,
    input  wire [ADDR_W-1:0] req_addr_in,
    input  wire [DATA_W-1:0] req_wdata_in,
    input  wire              busy_n_in,
    input  wire [DATA_W-1:0] ram_data_in,
    output reg               req_ready_out,
    output reg               rsp_valid_out,
    output reg  [DATA_W-1:0] rsp_rdata_out,
    output reg               sem_owned_out,
    output reg  [ADDR_W-1:0] ram_addr_out,
    output reg  [DATA_W-1:0] ram_data_out,
    output reg               ram_data_oe_n_out,
    output reg               port_select_n_out,
    output reg               token_select_n_out,
    output reg               write_strobe_n_out,
    output reg               output_drive_n_out
);

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam [`DPC_CNT_W-1:0] CYC_SETUP = `DPC_CYC_UP(`DPC_T_ADDR_SETUP_NS);
    localparam [`DPC_CNT_W-1:0] CYC_WRITE =
        `DPC_CYC_UP(`DPC_T_WRITE_PULSE_NS + `DPC_T_OUT_OFF_NS);
    localparam [`DPC_CNT_W-1:0] CYC_READ  =
        `DPC_CYC_UP(`DPC_T_READ_ACCESS_NS + `DPC_T_BUSY_VALID_NS);
    localparam [`DPC_CNT_W-1:0] CYC_HOLD  = `DPC_CYC_UP(`DPC_T_ADDR_HOLD_NS);
    localparam [`DPC_CNT_W-1:0] CYC_GAP   = `DPC_CYC_UP(`DPC_T_SEM_GAP_NS);

    // ------------------------------------------------------------
    // State and command codes
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE   = `DPC_ST_IDLE;
    localparam [2:0] ST_SETUP  = `DPC_ST_SETUP;
    localparam [2:0] ST_STROBE = `DPC_ST_STROBE;
    localparam [2:0] ST_HOLD   = `DPC_ST_HOLD;
    localparam [2:0] ST_GAP    = `DPC_ST_GAP;
    localparam [2:0] ST_WAIT   = `DPC_ST_WAIT;
    localparam [1:0] CMD_RAM_RD = `DPC_CMD_RAM_READ;
    localparam [1:0] CMD_RAM_WR = `DPC_CMD_RAM_WRITE;
    localparam [1:0] CMD_SEM_RD = `DPC_CMD_SEM_READ;
    localparam [1:0] CMD_SEM_WR = `DPC_CMD_SEM_WRITE;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg              busy_meta_q;
    reg              busy_sync_q;
    reg [DATA_W-1:0] rdata_meta_q;
    reg [DATA_W-1:0] rdata_sync_q;

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_meta_q  <= 1'b1;
            busy_sync_q  <= 1'b1;
            rdata_meta_q <= {DATA_W{1'b0}};
            rdata_sync_q <= {DATA_W{1'b0}};
        end else begin
            busy_meta_q  <= busy_n_in;
            busy_sync_q  <= busy_meta_q;
            rdata_meta_q <= ram_data_in;
            rdata_sync_q <= rdata_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    reg [2:0]            state_q;
    reg [`DPC_CNT_W-1:0] cnt_q;
    reg [1:0]            cmd_q;

    // Busy is honoured before every RAM and token write, so a write
    // never starts while the far side flags a clash
    wire cmd_write = (cmd_q == CMD_RAM_WR) || (cmd_q == CMD_SEM_WR);
    wire cmd_sem   = (cmd_q == CMD_SEM_RD) || (cmd_q == CMD_SEM_WR);
    wire cnt_done  = (cnt_q == {`DPC_CNT_W{1'b0}});

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q            <= `DPC_ST_IDLE;
            cnt_q              <= {`DPC_CNT_W{1'b0}};
            cmd_q              <= `DPC_CMD_RAM_READ;
            req_ready_out      <= 1'b1;
            rsp_valid_out      <= 1'b0;
            rsp_rdata_out      <= {DATA_W{1'b0}};
            sem_owned_out      <= 1'b0;
            ram_addr_out       <= {ADDR_W{1'b0}};
            ram_data_out       <= {DATA_W{1'b0}};
            ram_data_oe_n_out  <= 1'b1;
            port_select_n_out  <= 1'b1;
            token_select_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            output_drive_n_out <= 1'b1;
        end else begin
            rsp_valid_out <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_valid_in && req_ready_out) begin
                        // Address moves only while the strobe is high
                        req_ready_out      <= 1'b0;
                        cmd_q              <= req_cmd_in;
                        ram_addr_out       <= req_addr_in;
                        ram_data_out       <= req_wdata_in;
                        write_strobe_n_out <= 1'b1;
                        cnt_q              <= CYC_SETUP - 1'b1;
                        state_q            <= `DPC_ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_done) begin
                        // Exactly one select per access
                        port_select_n_out  <= cmd_sem;
                        token_select_n_out <= ~cmd_sem;
                        if (cmd_write) begin
                            // Every write: wait in ST_WAIT while busy holds writes off
                            state_q <= `DPC_ST_WAIT;
                        end else begin
                            // Fresh select strobe for each read
                            output_drive_n_out <= 1'b0;
                            cnt_q              <= CYC_READ - 1'b1;
                            state_q            <= `DPC_ST_STROBE;
                        end
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (busy_sync_q) begin
                        // Device floats its pins, so drive data now
                        ram_data_oe_n_out  <= 1'b0;
                        write_strobe_n_out <= 1'b0;
                        cnt_q              <= CYC_WRITE - 1'b1;
                        state_q            <= `DPC_ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    if (cmd_write && !busy_sync_q) begin
                        // Busy fell mid-write: restart the full pulse
                        cnt_q <= CYC_WRITE - 1'b1;
                    end else if (cnt_done) begin
                        // Write ends on strobe rise, data held past it
                        write_strobe_n_out <= 1'b1;
                        port_select_n_out  <= 1'b1;
                        token_select_n_out <= 1'b1;
                        output_drive_n_out <= 1'b1;
                        if (!cmd_write) begin
                            rsp_valid_out <= 1'b1;
                            rsp_rdata_out <= rdata_sync_q;
                        end
                        // Owner state from the token read-back, cleared by a token write of 1
                        if (cmd_q == `DPC_CMD_SEM_READ)
                            sem_owned_out <= ~rdata_sync_q[`DPC_SEM_BIT];
                        else if (cmd_q == `DPC_CMD_SEM_WRITE && ram_data_out[`DPC_SEM_BIT])
                            sem_owned_out <= 1'b0;
                        cnt_q   <= CYC_HOLD - 1'b1;
                        state_q <= `DPC_ST_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (cnt_done) begin
                        ram_data_oe_n_out <= 1'b1;
                        if (cmd_write)
                            rsp_valid_out <= 1'b1;
                        // Semaphore write-to-read gap before next strobe
                        cnt_q   <= CYC_GAP - 1'b1;
                        state_q <= `DPC_ST_GAP;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_GAP: begin
                    if (cnt_done) begin
                        req_ready_out <= 1'b1;
                        state_q       <= `DPC_ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= `DPC_ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### bench/dpc_port_props.sv
// Pin protocol checker for the port controller
`timescale 1ns/100ps
`default_nettype none
module dpc_port_props #(parameter ADDR_W = 13) (
    input wire logic              clk_sys_in,
    input wire logic              nrst_in,
    input wire logic [ADDR_W-1:0] ram_addr_out,
    input wire logic              ram_data_oe_n_out,
    input wire logic              port_select_n_out,
    input wire logic              token_select_n_out,
    input wire logic              write_strobe_n_out,
    input wire logic              output_drive_n_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    sequence s_sem_rd; !token_select_n_out && !output_drive_n_out; endsequence
    sequence s_sem_wr; !token_select_n_out && !write_strobe_n_out; endsequence
    a_read_no_write: assert property (!output_drive_n_out |-> write_strobe_n_out)
        else $error("write strobe low during a read");
    a_one_select: assert property (!port_select_n_out |-> token_select_n_out)
        else $error("array and token selects low together");
    a_addr_no_write: assert property ($changed(ram_addr_out) |->
        write_strobe_n_out && $past(write_strobe_n_out))
        else $error("address moved during a write");
    a_sem_read_strobe: assert property (s_sem_rd |-> $stable(ram_addr_out))
        else $error("token read by address change");
    a_sem_write_sel: assert property (s_sem_wr |->
        port_select_n_out && !ram_data_oe_n_out)
        else $error("token write without array deselect or data drive");
endmodule
bind dpc_port_ctrl dpc_port_props #(.ADDR_W(ADDR_W)) i_dpc_port_props (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ram_addr_out(ram_addr_out),
    .ram_data_oe_n_out(ram_data_oe_n_out), .port_select_n_out(port_select_n_out),
    .token_select_n_out(token_select_n_out), .write_strobe_n_out(write_strobe_n_out),
    .output_drive_n_out(output_drive_n_out));
`default_nettype wire

// ### bench/dpc_ram_model.sv
// Behavioural model of one port of the dual-port RAM
`timescale 1ns/100ps
`default_nettype none
module dpc_ram_model (
    input  wire logic        clk_in,
    input  wire logic [12:0] addr_in,
    input  wire logic [8:0]  data_in,
    input  wire logic        cs_n_in,
    input  wire logic        ts_n_in,
    input  wire logic        we_n_in,
    input  wire logic        oe_n_in,
    input  wire logic [7:0]  oth_in,
    output logic      [8:0]  data_out
);
    logic [8:0] mem [0:15];
    logic [7:0] own = 8'h00;
    logic [8:0] last = 9'h000;
    logic       rs;
    wire wr = !we_n_in && (!cs_n_in || !ts_n_in);
    wire rd = we_n_in && !oe_n_in && (!cs_n_in || !ts_n_in);
    always @(posedge wr) rs <= !cs_n_in;
    always @(negedge wr) begin
        if (rs) mem[addr_in[3:0]] <= data_in;
        else if (data_in[0]) own[addr_in[2:0]] <= 1'b0;
        else if (!oth_in[addr_in[2:0]]) own[addr_in[2:0]] <= 1'b1;
    end
    // Released pins show the inverse of the last value driven
    always @* data_out = rd ? (!cs_n_in ? mem[addr_in[3:0]] : {8'hff, ~own[addr_in[2:0]]}) : ~last;
    always @(posedge clk_in) if (rd) last <= data_out;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench for the port controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk_sys_in = 0, nrst_in = 0, req_valid_in = 0, busy_n_in = 1;
    logic [1:0]  req_cmd_in = 0;
    logic [12:0] req_addr_in = 0;
    logic [8:0]  req_wdata_in = 0, rd;
    logic [7:0]  oth = 0;
    int          fails = 0, tests_run = 0;
    wire         req_ready_out, rsp_valid_out, sem_owned_out, oe_n, cs_n, ts_n, we_n, od_n;
    wire  [8:0]  rsp_rdata_out, dout, dq, din;
    wire  [12:0] addr;
    assign din = oe_n ? dq : dout;
    always #4 clk_sys_in = ~clk_sys_in;
    dpc_port_ctrl i_dpc_port_ctrl (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .busy_n_in(busy_n_in), .ram_data_in(din),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .sem_owned_out(sem_owned_out), .ram_addr_out(addr),
        .ram_data_out(dout), .ram_data_oe_n_out(oe_n), .port_select_n_out(cs_n),
        .token_select_n_out(ts_n), .write_strobe_n_out(we_n), .output_drive_n_out(od_n));
    dpc_ram_model i_dpc_ram_model (.clk_in(clk_sys_in), .addr_in(addr), .data_in(dout),
        .cs_n_in(cs_n), .ts_n_in(ts_n), .we_n_in(we_n), .oe_n_in(od_n), .oth_in(oth),
        .data_out(dq));
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t expected %h got %h", $time, e, g);
        end
    endtask
    task automatic tick(inout int n);
        @(negedge clk_sys_in);
        n++;
        if (n > 99) begin
            fails++;
            $display("[FAIL] %0t handshake timeout", $time);
            tally_and_finish;
        end
    endtask
    task automatic issue(input logic [1:0] c, input logic [12:0] a, input logic [8:0] w);
        int n;
        n = 0;
        while (req_ready_out !== 1'b1) tick(n);
        req_cmd_in = c;
        req_addr_in = a;
        req_wdata_in = w;
        req_valid_in = 1;
        @(negedge clk_sys_in);
        req_valid_in = 0;
    endtask
    task automatic wait_rsp;
        int n;
        n = 0;
        while (rsp_valid_out !== 1'b1) tick(n);
        rd = rsp_rdata_out;
    endtask
    task automatic req(input logic [1:0] c, input logic [12:0] a, input logic [8:0] w);
        issue(c, a, w);
        wait_rsp;
    endtask
    task automatic t_ram;
        for (int i = 0; i < 3; i++) req(2'h1, 13'(i * 5), 9'h1a5 ^ 9'(i));
        for (int i = 0; i < 3; i++) begin
            req(2'h0, 13'(i * 5), 9'h000);
            chk(9'h1a5 ^ 9'(i), rd);
        end
        $display("t_ram done");
    endtask
    task automatic t_sem;
        req(2'h2, 13'h0003, 9'h000);
        chk(1'b1, rd[0]);
        req(2'h3, 13'h0003, 9'h000);
        req(2'h2, 13'h0003, 9'h000);
        @(negedge clk_sys_in);
        chk(1'b0, rd[0]);
        chk(1'b1, sem_owned_out);
        req(2'h3, 13'h0003, 9'h001);
        req(2'h2, 13'h0003, 9'h000);
        @(negedge clk_sys_in);
        chk(1'b1, rd[0]);
        chk(1'b0, sem_owned_out);
        $display("t_sem done");
    endtask
    task automatic t_contend;
        oth[5] = 1;
        req(2'h3, 13'h0005, 9'h000);
        req(2'h2, 13'h0005, 9'h000);
        @(negedge clk_sys_in);
        chk(1'b1, rd[0]);
        chk(1'b0, sem_owned_out);
        oth[5] = 0;
        $display("t_contend done");
    endtask
    task automatic t_busy;
        busy_n_in = 0;
        issue(2'h1, 13'h0007, 9'h0c3);
        repeat (20) begin
            @(negedge clk_sys_in);
            chk(1'b1, we_n);
        end
        busy_n_in = 1;
        wait_rsp;
        req(2'h0, 13'h0007, 9'h000);
        chk(9'h0c3, rd);
        $display("t_busy done");
    endtask
    initial begin
        repeat (10) @(negedge clk_sys_in);
        nrst_in = 1;
        t_ram;
        t_sem;
        t_contend;
        t_busy;
        tally_and_finish;
    end
endmodule
`default_nettype wire
